//--- pkg/pesl_pkg.sv
package pesl_pkg;
    // register indices; byte address is four times the index
    localparam logic [29:0] IDX_SUMMARY = 30'h0000_4010;
    localparam logic [29:0] IDX_ST_PWR = 30'h0000_4012;
    localparam logic [29:0] IDX_ST_LIN = 30'h0000_4013;
    localparam logic [29:0] IDX_ST_CNV = 30'h0000_4014;
    localparam logic [29:0] IDX_MASK = 30'h0000_4018;
    localparam logic [29:0] IDX_SUM_CLR = 30'h0000_4019;

    localparam int NWORDS = 3;
    localparam int WPWR = 0;
    localparam int WLIN = 1;
    localparam int WCNV = 2;

    // power and memory word
    localparam int B_NVM_DONE = 5;
    localparam int B_NVM_FAIL = 4;
    localparam int B_POR = 2;
    localparam int B_SLEEP_OFF = 1;
    localparam int B_ON = 0;
    // converter and crystal word
    localparam int B_HC1 = 8;
    localparam int B_HC2 = 9;
    localparam int B_XTAL_START = 7;
    localparam int B_XTAL_TAMPER = 6;
    localparam int B_CNV_UV0 = 0;
    localparam int N_LIN = 10;
    localparam int N_CNV = 4;

    localparam logic [15:0] IMPL_PWR = 16'h0037;
    localparam logic [15:0] IMPL_LIN = 16'h03ff;
    localparam logic [15:0] IMPL_CNV = 16'h03cf;
    localparam logic [15:0] BOTH_CNV = 16'h0040;
    localparam logic [15:0] FLAG_RST = 16'h0000;

    // summary / mask word
    localparam int S_PS = 15;
    localparam int S_XTAL = 5;
    localparam int S_NVM = 4;
    localparam int S_HC = 1;
    localparam int S_UV = 0;
    localparam logic [15:0] IMPL_SUM = 16'h8033;
    localparam logic [15:0] MASK_RST = 16'h8033;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- verilog/pesl_edge_bank.sv
module pesl_edge_bank #(
    parameter int W = 16,
    parameter logic [W-1:0] BOTH = '0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [W-1:0] level_i,
    output logic [W-1:0] pulse_o
);
    logic [W-1:0] prev_ff;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= level_i;
        end
    end

    // a source already high at release counts as a rising edge
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            if (BOTH[i]) begin : g_any
                assign pulse_o[i] = level_i[i] ^ prev_ff[i];
            end else begin : g_rise
                assign pulse_o[i] = level_i[i] & ~prev_ff[i];
            end
        end
    endgenerate
endmodule

//--- verilog/pesl_axil_slave.sv
module pesl_axil_slave (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [31:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [31:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic wr_go_o,
    output logic [29:0] wr_idx_o,
    output logic [31:0] wr_data_o,
    output logic [3:0] wr_strb_o,
    input wire logic wr_ok_i,
    output logic [29:0] rd_idx_o,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_ok_i
);
    logic aw_ff;
    logic w_ff;
    logic [29:0] awidx_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    wire aw_take = awvalid_i & awready_o;
    wire w_take = wvalid_i & wready_o;
    wire ar_take = arvalid_i & arready_o;

    assign awready_o = ~aw_ff & ~bvalid_ff;
    assign wready_o = ~w_ff & ~bvalid_ff;
    assign arready_o = ~rvalid_ff;
    assign wr_go_o = aw_ff & w_ff & ~bvalid_ff;
    assign wr_idx_o = awidx_ff;
    assign wr_data_o = wdata_ff;
    assign wr_strb_o = wstrb_ff;
    assign rd_idx_o = araddr_i[31:2];
    assign bvalid_o = bvalid_ff;
    assign bresp_o = bresp_ff;
    assign rvalid_o = rvalid_ff;
    assign rresp_o = rresp_ff;
    assign rdata_o = rdata_ff;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awidx_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= pesl_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_ff <= 1'b1;
                awidx_ff <= awaddr_i[31:2];
            end
            if (w_take) begin
                w_ff <= 1'b1;
                wdata_ff <= wdata_i;
                wstrb_ff <= wstrb_i;
            end
            if (wr_go_o) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok_i ? pesl_pkg::RESP_OKAY : pesl_pkg::RESP_SLVERR;
            end else if (bvalid_ff & bready_i) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= pesl_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_ok_i ? rd_data_i : 32'h0000_0000;
            rresp_ff <= rd_ok_i ? pesl_pkg::RESP_OKAY : pesl_pkg::RESP_SLVERR;
        end else if (rvalid_ff & rready_i) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule

//--- verilog/pesl_event_latches.sv
module pesl_event_latches (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic nvm_done_i,
    input wire logic nvm_fail_i,
    input wire logic power_on_reset_i,
    input wire logic enter_sleep_or_off_i,
    input wire logic enter_on_i,
    input wire logic [9:0] linear_reg_uv_i,
    input wire logic [3:0] converter_uv_i,
    input wire logic [1:0] converter_hc_i,
    input wire logic crystal_start_fail_i,
    input wire logic crystal_tamper_i,
    output logic [15:0] status_power_and_memory_o,
    output logic [15:0] status_linear_undervoltage_o,
    output logic [15:0] status_converter_and_crystal_o,
    output logic [15:0] summary_o,
    output logic irq_o
);
    logic [15:0] level_pwr;
    logic [15:0] level_lin;
    logic [15:0] level_cnv;
    logic [15:0] pulse_pwr;
    logic [15:0] pulse_lin;
    logic [15:0] pulse_cnv;
    logic [15:0] set_w [pesl_pkg::NWORDS];
    logic [15:0] clr_w [pesl_pkg::NWORDS];
    logic [15:0] impl_w [pesl_pkg::NWORDS];
    logic [15:0] flag_ff [pesl_pkg::NWORDS];
    logic [15:0] nxt_flag [pesl_pkg::NWORDS];
    logic [15:0] mask_ff;
    logic [15:0] summary;
    logic [15:0] sum_clr;
    logic [15:0] wr_bits;
    logic wr_go;
    logic [29:0] wr_idx;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [29:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_ok;

    pesl_axil_slave u_bus (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .awaddr_i(s_axi_awaddr_i),
        .awvalid_i(s_axi_awvalid_i),
        .awready_o(s_axi_awready_o),
        .wdata_i(s_axi_wdata_i),
        .wstrb_i(s_axi_wstrb_i),
        .wvalid_i(s_axi_wvalid_i),
        .wready_o(s_axi_wready_o),
        .bresp_o(s_axi_bresp_o),
        .bvalid_o(s_axi_bvalid_o),
        .bready_i(s_axi_bready_i),
        .araddr_i(s_axi_araddr_i),
        .arvalid_i(s_axi_arvalid_i),
        .arready_o(s_axi_arready_o),
        .rdata_o(s_axi_rdata_o),
        .rresp_o(s_axi_rresp_o),
        .rvalid_o(s_axi_rvalid_o),
        .rready_i(s_axi_rready_i),
        .wr_go_o(wr_go),
        .wr_idx_o(wr_idx),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .wr_ok_i(wr_ok),
        .rd_idx_o(rd_idx),
        .rd_data_i(rd_data),
        .rd_ok_i(rd_ok)
    );

    // place each source at the bit position of its flag
    always_comb begin
        level_pwr = 16'h0000;
        level_pwr[pesl_pkg::B_NVM_DONE] = nvm_done_i;
        level_pwr[pesl_pkg::B_NVM_FAIL] = nvm_fail_i;
        level_pwr[pesl_pkg::B_POR] = power_on_reset_i;
        level_pwr[pesl_pkg::B_SLEEP_OFF] = enter_sleep_or_off_i;
        level_pwr[pesl_pkg::B_ON] = enter_on_i;
    end

    always_comb begin
        level_lin = 16'h0000;
        level_lin[pesl_pkg::N_LIN-1:0] = linear_reg_uv_i;
    end

    always_comb begin
        level_cnv = 16'h0000;
        level_cnv[pesl_pkg::B_CNV_UV0+:pesl_pkg::N_CNV] = converter_uv_i;
        level_cnv[pesl_pkg::B_HC1] = converter_hc_i[0];
        level_cnv[pesl_pkg::B_HC2] = converter_hc_i[1];
        level_cnv[pesl_pkg::B_XTAL_START] = crystal_start_fail_i;
        level_cnv[pesl_pkg::B_XTAL_TAMPER] = crystal_tamper_i;
    end

    pesl_edge_bank #(
        .W(16),
        .BOTH(16'h0000)
    ) u_edge_pwr (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(level_pwr),
        .pulse_o(pulse_pwr)
    );

    pesl_edge_bank #(
        .W(16),
        .BOTH(16'h0000)
    ) u_edge_lin (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(level_lin),
        .pulse_o(pulse_lin)
    );

    // tamper is flagged on any change, not only on assertion
    pesl_edge_bank #(
        .W(16),
        .BOTH(pesl_pkg::BOTH_CNV)
    ) u_edge_cnv (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(level_cnv),
        .pulse_o(pulse_cnv)
    );

    // register decode
    wire wr_pwr = wr_go & (wr_idx == pesl_pkg::IDX_ST_PWR);
    wire wr_lin = wr_go & (wr_idx == pesl_pkg::IDX_ST_LIN);
    wire wr_cnv = wr_go & (wr_idx == pesl_pkg::IDX_ST_CNV);
    wire wr_mask = wr_go & (wr_idx == pesl_pkg::IDX_MASK);
    wire wr_sclr = wr_go & (wr_idx == pesl_pkg::IDX_SUM_CLR);
    wire wr_sum = wr_go & (wr_idx == pesl_pkg::IDX_SUMMARY);
    assign wr_ok = wr_pwr | wr_lin | wr_cnv | wr_mask | wr_sclr | wr_sum;

    // byte enables gate which half of the 16-bit word is touched
    assign wr_bits = wr_data[15:0] & {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign sum_clr = wr_sclr ? wr_bits : 16'h0000;

    // a summary clear wipes every flag of its group
    wire clr_ps = sum_clr[pesl_pkg::S_PS];
    wire clr_nvm = sum_clr[pesl_pkg::S_NVM];
    wire clr_hc = sum_clr[pesl_pkg::S_HC];
    wire clr_uv = sum_clr[pesl_pkg::S_UV];
    wire clr_xt = sum_clr[pesl_pkg::S_XTAL];

    wire [15:0] grp_pwr = {10'h000, {2{clr_nvm}}, 1'b0, {3{clr_ps}}};
    wire [15:0] grp_lin = {16{clr_uv}};
    wire [15:0] grp_cnv = {6'h00, {2{clr_hc}}, {2{clr_xt}}, 2'h0, {4{clr_uv}}};

    assign impl_w[pesl_pkg::WPWR] = pesl_pkg::IMPL_PWR;
    assign impl_w[pesl_pkg::WLIN] = pesl_pkg::IMPL_LIN;
    assign impl_w[pesl_pkg::WCNV] = pesl_pkg::IMPL_CNV;
    assign set_w[pesl_pkg::WPWR] = pulse_pwr;
    assign set_w[pesl_pkg::WLIN] = pulse_lin;
    assign set_w[pesl_pkg::WCNV] = pulse_cnv;
    assign clr_w[pesl_pkg::WPWR] = (wr_pwr ? wr_bits : 16'h0000) | grp_pwr;
    assign clr_w[pesl_pkg::WLIN] = (wr_lin ? wr_bits : 16'h0000) | grp_lin;
    assign clr_w[pesl_pkg::WCNV] = (wr_cnv ? wr_bits : 16'h0000) | grp_cnv;

    // unused bits are held low so they never read back as set
    genvar w;
    generate
        for (w = 0; w < pesl_pkg::NWORDS; w++) begin : g_word
            // set beats a same-cycle clear, so no event is lost
            assign nxt_flag[w] = (set_w[w] | (flag_ff[w] & ~clr_w[w])) & impl_w[w];
            always_ff @(posedge clock_i) begin
                if (rst_i) begin
                    flag_ff[w] <= pesl_pkg::FLAG_RST;
                end else begin
                    flag_ff[w] <= nxt_flag[w];
                end
            end
        end
    endgenerate

    wire [15:0] st_pwr = flag_ff[pesl_pkg::WPWR];
    wire [15:0] st_lin = flag_ff[pesl_pkg::WLIN];
    wire [15:0] st_cnv = flag_ff[pesl_pkg::WCNV];

    // summary bits are live ORs, so clearing the flags drops them
    always_comb begin
        summary = 16'h0000;
        summary[pesl_pkg::S_PS] = |st_pwr[2:0];
        summary[pesl_pkg::S_NVM] = |st_pwr[5:4];
        summary[pesl_pkg::S_HC] = |st_cnv[9:8];
        summary[pesl_pkg::S_UV] = (|st_lin[9:0]) | (|st_cnv[3:0]);
        summary[pesl_pkg::S_XTAL] = |st_cnv[7:6];
    end

    // mask of one blocks the group from the interrupt line
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mask_ff <= pesl_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_ff <= ((mask_ff & ~{{8{wr_strb[1]}}, {8{wr_strb[0]}}}) | wr_bits)
                & pesl_pkg::IMPL_SUM;
        end
    end

    // read mux; clear register reads zero
    wire rd_sum = rd_idx == pesl_pkg::IDX_SUMMARY;
    wire rd_pwr = rd_idx == pesl_pkg::IDX_ST_PWR;
    wire rd_lin = rd_idx == pesl_pkg::IDX_ST_LIN;
    wire rd_cnv = rd_idx == pesl_pkg::IDX_ST_CNV;
    wire rd_msk = rd_idx == pesl_pkg::IDX_MASK;
    wire rd_clr = rd_idx == pesl_pkg::IDX_SUM_CLR;
    assign rd_ok = rd_sum | rd_pwr | rd_lin | rd_cnv | rd_msk | rd_clr;
    wire [15:0] rd_word = rd_sum ? summary :
                          rd_pwr ? st_pwr :
                          rd_lin ? st_lin :
                          rd_cnv ? st_cnv :
                          rd_msk ? mask_ff : 16'h0000;
    assign rd_data = {16'h0000, rd_word};

    logic irq_ff;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(summary & ~mask_ff);
        end
    end

    assign status_power_and_memory_o = st_pwr;
    assign status_linear_undervoltage_o = st_lin;
    assign status_converter_and_crystal_o = st_cnv;
    assign summary_o = summary;
    assign irq_o = irq_ff;
endmodule

//--- test/pesl_event_latches_asserts.sv
module pesl_chk (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic nvm_done_i,
    input wire logic nvm_fail_i,
    input wire logic power_on_reset_i,
    input wire logic enter_sleep_or_off_i,
    input wire logic enter_on_i,
    input wire logic [9:0] linear_reg_uv_i,
    input wire logic [3:0] converter_uv_i,
    input wire logic [1:0] converter_hc_i,
    input wire logic crystal_start_fail_i,
    input wire logic crystal_tamper_i,
    input wire logic [15:0] status_power_and_memory_o,
    input wire logic [15:0] status_linear_undervoltage_o,
    input wire logic [15:0] status_converter_and_crystal_o,
    input wire logic [15:0] summary_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wrote_ff;
    logic [47:0] all_flags;
    logic [15:0] pw;
    logic [15:0] ln;
    logic [15:0] cv;
    assign pw = status_power_and_memory_o;
    assign ln = status_linear_undervoltage_o;
    assign cv = status_converter_and_crystal_o;
    assign all_flags = {cv, ln, pw};
    // mask leaves reset with every summary bit set (8033), so no irq can show before the first write
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wrote_ff <= 1'b0;
        end else begin
            wrote_ff <= wrote_ff | s_axi_bvalid_o;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_done; $rose(nvm_done_i) |=> pw[5]; endproperty
    a_done: assert property (p_done) else $error("nvm done flag not set");
    property p_fail; $rose(nvm_fail_i) |=> pw[4]; endproperty
    a_fail: assert property (p_fail) else $error("nvm fail flag not set");
    property p_por; $rose(power_on_reset_i) |=> pw[2]; endproperty
    a_por: assert property (p_por) else $error("por flag not set");
    property p_sleep; $rose(enter_sleep_or_off_i) |=> pw[1]; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flag not set");
    property p_on; $rose(enter_on_i) |=> pw[0]; endproperty
    a_on: assert property (p_on) else $error("on flag not set");
    property p_lin;
        !$past(rst_i) |-> ((~ln[9:0] & $past(linear_reg_uv_i) & ~$past(linear_reg_uv_i, 2)) == 10'h000);
    endproperty
    a_lin: assert property (p_lin) else $error("linear uv flag missed");
    property p_cuv;
        !$past(rst_i) |-> ((~cv[3:0] & $past(converter_uv_i) & ~$past(converter_uv_i, 2)) == 4'h0);
    endproperty
    a_cuv: assert property (p_cuv) else $error("converter uv flag missed");
    property p_hc;
        !$past(rst_i) |-> ((~cv[9:8] & $past(converter_hc_i) & ~$past(converter_hc_i, 2)) == 2'h0);
    endproperty
    a_hc: assert property (p_hc) else $error("high current flag missed");
    property p_xst; $rose(crystal_start_fail_i) |=> cv[7]; endproperty
    a_xst: assert property (p_xst) else $error("crystal start flag not set");
    property p_tamp; $changed(crystal_tamper_i) |=> cv[6]; endproperty
    a_tamp: assert property (p_tamp) else $error("tamper flag not set");
    property p_sticky;
        (!$past(rst_i) && (($past(all_flags) & ~all_flags) != 48'h0)) |-> $rose(s_axi_bvalid_o);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag fell without a write");
    property p_sum;
        summary_o[15:0] == {|pw[2:0], 9'h000, |cv[7:6], |pw[5:4], 2'h0, |cv[9:8], |ln[9:0] | |cv[3:0]};
    endproperty
    a_sum: assert property (p_sum) else $error("summary bits wrong");
    property p_mask; !wrote_ff |-> !irq_o; endproperty
    a_mask: assert property (p_mask) else $error("irq before any unmask");
    c_irq: cover property ($rose(irq_o));
    c_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
    c_tfall: cover property ($fell(crystal_tamper_i) ##1 cv[6]);
endmodule

bind pesl_event_latches pesl_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o), .nvm_done_i(nvm_done_i),
    .nvm_fail_i(nvm_fail_i), .power_on_reset_i(power_on_reset_i),
    .enter_sleep_or_off_i(enter_sleep_or_off_i), .enter_on_i(enter_on_i),
    .linear_reg_uv_i(linear_reg_uv_i), .converter_uv_i(converter_uv_i),
    .converter_hc_i(converter_hc_i), .crystal_start_fail_i(crystal_start_fail_i),
    .crystal_tamper_i(crystal_tamper_i), .status_power_and_memory_o(status_power_and_memory_o),
    .status_linear_undervoltage_o(status_linear_undervoltage_o),
    .status_converter_and_crystal_o(status_converter_and_crystal_o),
    .summary_o(summary_o), .irq_o(irq_o));

//--- test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i;
    logic rst_i;
    logic [31:0] awaddr, wdata, araddr, rdata, rdv;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp;
    logic [3:0] strb;
    logic [22:0] ev;
    logic [15:0] summary;
    logic [47:0] e;
    int fails, num_checks, cycles;
    pesl_event_latches u_dut (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .nvm_done_i(ev[0]), .nvm_fail_i(ev[1]),
        .power_on_reset_i(ev[2]), .enter_sleep_or_off_i(ev[3]), .enter_on_i(ev[4]),
        .linear_reg_uv_i(ev[14:5]), .converter_uv_i(ev[18:15]), .converter_hc_i(ev[20:19]),
        .crystal_start_fail_i(ev[21]), .crystal_tamper_i(ev[22]),
        .status_power_and_memory_o(), .status_linear_undervoltage_o(),
        .status_converter_and_crystal_o(), .summary_o(summary), .irq_o(irq));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [29:0] i, input logic [15:0] d);
        @(posedge clock_i);
        awaddr <= {i, 2'h0};
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [29:0] i);
        @(posedge clock_i);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rdv = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic wr3(input logic [15:0] d);
        wr(pesl_pkg::IDX_ST_PWR, d);
        wr(pesl_pkg::IDX_ST_LIN, d);
        wr(pesl_pkg::IDX_ST_CNV, d);
    endtask
    task automatic check_all(input logic [47:0] x);
        rd(pesl_pkg::IDX_ST_PWR);
        chk("power word", rdv, {16'h0000, x[15:0]});
        rd(pesl_pkg::IDX_ST_LIN);
        chk("linear word", rdv, {16'h0000, x[31:16]});
        rd(pesl_pkg::IDX_ST_CNV);
        chk("converter word", rdv, {16'h0000, x[47:32]});
        chk("summary", {16'h0000, summary}, {16'h0000, |x[2:0], 9'h000, |x[39:38], |x[5:4],
            2'h0, |x[41:40], |x[31:16] | |x[35:32]});
    endtask
    // flag position of each event input, packed as {converter, linear, power}
    function automatic int pos(input int i);
        if (i < 5) return (i < 2) ? 5 - i : 4 - i;
        if (i < 15) return i + 11;
        if (i < 19) return i + 17;
        if (i < 21) return i + 21;
        return 60 - i;
    endfunction
    task automatic t_reset();
        check_all(48'h0);
        rd(pesl_pkg::IDX_MASK);
        chk("mask reset", rdv, 32'h0000_8033);
        chk("mask read resp", {30'h0, resp}, {30'h0, pesl_pkg::RESP_OKAY});
        $display("test reset done");
    endtask
    task automatic t_events();
        for (int i = 0; i < 23; i++) begin
            e = 48'h0;
            e[pos(i)] = 1'b1;
            @(posedge clock_i);
            ev[i] <= 1'b1;
            check_all(e);
            chk("irq masked", {31'h0, irq}, 32'h0);
            wr3(16'h0000);
            check_all(e);
            // cleared while the level is still high: a level must not set it again
            // odd events go through the group clear, even ones through the words
            if (i % 2) begin
                wr(pesl_pkg::IDX_SUM_CLR, 16'h8033);
            end else begin
                wr3(16'hffff);
            end
            ev[i] <= 1'b0;
            check_all((i == 22) ? e : 48'h0);
            wr3(16'hffff);
        end
        $display("test events done");
    endtask
    task automatic t_bus();
        wr(30'h0000_4011, 16'hffff);
        chk("unmapped write resp", {30'h0, resp}, {30'h0, pesl_pkg::RESP_SLVERR});
        rd(30'h0000_4011);
        chk("unmapped read resp", {30'h0, resp}, {30'h0, pesl_pkg::RESP_SLVERR});
        chk("unmapped read data", rdv, 32'h0);
        strb <= 4'h1;
        wr(pesl_pkg::IDX_MASK, 16'h0000);
        strb <= 4'hf;
        rd(pesl_pkg::IDX_MASK);
        chk("mask low lane", rdv, 32'h0000_8000);
        wr(pesl_pkg::IDX_SUMMARY, 16'hffff);
        chk("summary write resp", {30'h0, resp}, {30'h0, pesl_pkg::RESP_OKAY});
        $display("test bus done");
    endtask
    task automatic t_irq();
        wr(pesl_pkg::IDX_MASK, 16'h0000);
        ev[19] <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wr(pesl_pkg::IDX_MASK, 16'h0002);
        repeat (2) @(posedge clock_i);
        chk("irq masked again", {31'h0, irq}, 32'h0);
        wr(pesl_pkg::IDX_MASK, 16'h0000);
        wr(pesl_pkg::IDX_SUM_CLR, 16'h0002);
        ev[19] <= 1'b0;
        check_all(48'h0);
        repeat (2) @(posedge clock_i);
        chk("irq after group clear", {31'h0, irq}, 32'h0);
        $display("test irq done");
    endtask
    task automatic t_race();
        // the rising edge lands on the very edge that applies the clear
        fork
            wr(pesl_pkg::IDX_ST_PWR, 16'h0020);
            begin
                repeat (2) @(posedge clock_i);
                ev[0] <= 1'b1;
            end
        join
        check_all(48'h20);
        ev[0] <= 1'b0;
        wr3(16'hffff);
        $display("test race done");
    endtask
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        {rst_i, awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
        ev = '0;
        strb = 4'hf;
        rst_i = 1'b1;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_events();
        t_bus();
        t_irq();
        t_race();
        conclude();
    end
    // the whole run needs about 1500 cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end
endmodule
